/* core/sbsp_ctrl.sv */
`timescale 1ns/1ps
module sbsp_ctrl import sbsp_pkg::*; #(
	parameter int ADDR_HI_W = SBSP_ADDR_HI_W,
	parameter int FIFO_DEPTH = SBSP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// address pins
	input wire logic [ADDR_HI_W-1:0] addr_hi,
	input wire logic burst_start_bit_zero,
	input wire logic burst_start_bit_one,
	// write control pins
	input wire logic byte_lane_write_n_0,
	input wire logic byte_lane_write_n_1,
	input wire logic byte_lane_write_n_2,
	input wire logic byte_lane_write_n_3,
	input wire logic write_n,
	// burst and clock control pins
	input wire logic burst_step_or_load,
	input wire logic clock_gate_n,
	// chip selects
	input wire logic chip_select_low_a,
	input wire logic chip_select_high,
	input wire logic chip_select_low_b,
	// asynchronous output enable
	input wire logic output_enable_n,
	// burst order strap
	input wire logic burst_order_strap,
	// data pins, parity lane in bit 8 of each lane
	input wire logic [SBSP_DATA_W-1:0] dq_in,
	output logic [SBSP_DATA_W-1:0] dq_out,
	output logic dq_oe,
	// write buffer has room
	output logic write_buffer_ready
);
	// full word address width and buffer entry width
	localparam int ADDR_W = ADDR_HI_W + SBSP_BURST_W;
	localparam int ENT_W = ADDR_W + SBSP_LANES + SBSP_DATA_W;
	localparam int WORDS = 1 << ADDR_W;

	// edge qualification and command decode
	logic qual; // clock recognised this edge
	logic selected; // chip select combination true
	logic load_cmd; // new address this edge
	logic step_cmd; // burst advance this edge
	logic [SBSP_LANES-1:0] lane_wr_n; // byte strobes gathered

	// held control state
	sbsp_op_e op_reg; // operation of the current cycle
	logic [ADDR_HI_W-1:0] addr_hi_reg; // upper address, fixed in burst
	logic [SBSP_BURST_W-1:0] start_reg; // loaded low bits
	logic [SBSP_BURST_W-1:0] cnt_reg; // burst position
	logic [SBSP_LANES-1:0] lane_en_reg; // byte lanes to write
	logic emerge_reg; // first cycle after deselect
	logic linear_reg; // burst order caught from strap

	// derived address
	logic [SBSP_BURST_W-1:0] low_addr; // low bits after ordering
	logic [ADDR_W-1:0] cur_addr; // location of this cycle

	// storage
	logic [SBSP_DATA_W-1:0] mem_reg [WORDS]; // memory array

	// write buffer fields on the drain side
	logic [ADDR_W-1:0] ent_addr; // target location
	logic [SBSP_LANES-1:0] ent_lanes; // lanes to store
	logic [SBSP_DATA_W-1:0] ent_data; // data word
	logic drain; // entry leaves buffer

	// write buffer handshake bundle
	sbsp_fifo_if #(.WIDTH(ENT_W)) wbuf ();

	// write buffer instance
	sbsp_fifo_buf #(
		.WIDTH(ENT_W),
		.DEPTH(FIFO_DEPTH)
	) u_wbuf (
		.mclk(mclk),
		.srst(srst),
		.link(wbuf.store)
	);

	// edge is seen only with the gate low
	assign qual = ~clock_gate_n;

	// select is low, high, low, all else deselects
	assign selected = ~chip_select_low_a & chip_select_high &
		~chip_select_low_b;

	// advance low loads, advance high steps
	assign load_cmd = qual & ~burst_step_or_load;
	assign step_cmd = qual & burst_step_or_load;

	// byte strobes in lane order
	assign lane_wr_n = {byte_lane_write_n_3, byte_lane_write_n_2,
		byte_lane_write_n_1, byte_lane_write_n_0};

	// ordered low bits from start and position
	assign low_addr = sbsp_burst_off(start_reg, cnt_reg, linear_reg);

	// upper bits never move during a burst
	assign cur_addr = {addr_hi_reg, low_addr};

	// operation state, moves only on qualified edges
	always_ff @(posedge mclk) begin
		if (srst) begin
			op_reg <= SBSP_OP_IDLE;
		end else if (load_cmd) begin
			// new access or deselect
			if (!selected) begin
				op_reg <= SBSP_OP_IDLE;
			end else if (!write_n) begin
				// write starts only with the strobe low
				op_reg <= SBSP_OP_WRITE;
			end else begin
				op_reg <= SBSP_OP_READ;
			end
		end
		// a step keeps the operation, a gated edge holds all
	end

	// address capture and burst counter
	always_ff @(posedge mclk) begin
		if (srst) begin
			addr_hi_reg <= '0;
			start_reg <= SBSP_CNT_ZERO;
			cnt_reg <= SBSP_CNT_ZERO;
		end else if (load_cmd && selected) begin
			// full address taken, low bits held as start, counter cleared
			addr_hi_reg <= addr_hi;
			start_reg <= {burst_start_bit_one, burst_start_bit_zero};
			cnt_reg <= SBSP_CNT_ZERO;
		end else if (step_cmd && op_reg != SBSP_OP_IDLE) begin
			// two-bit count wraps inside a group of four
			cnt_reg <= cnt_reg + SBSP_CNT_ONE;
		end
	end

	// byte strobes sampled each qualified edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			lane_en_reg <= '0;
		end else if (qual) begin
			// active low, acted on only in a write
			lane_en_reg <= ~lane_wr_n;
		end
	end

	// marks the first cycle after leaving deselect
	always_ff @(posedge mclk) begin
		if (srst) begin
			emerge_reg <= 1'h0;
		end else if (qual) begin
			emerge_reg <= load_cmd && selected &&
				op_reg == SBSP_OP_IDLE;
		end
	end

	// strap caught while reset is held
	always_ff @(posedge mclk) begin
		if (srst) begin
			linear_reg <= (burst_order_strap == SBSP_STRAP_LINEAR);
		end
	end

	// write data phase: data taken at the next qualified edge
	assign wbuf.in_valid = qual && op_reg == SBSP_OP_WRITE &&
		(|lane_en_reg);
	assign wbuf.in_data = {cur_addr, lane_en_reg, dq_in};
	assign write_buffer_ready = wbuf.in_ready;

	// drain stalls while gated or while a read owns the array
	assign wbuf.out_ready = qual && op_reg != SBSP_OP_READ;
	assign {ent_addr, ent_lanes, ent_data} = wbuf.out_data;
	assign drain = wbuf.out_valid && wbuf.out_ready;

	// array update, per byte lane
	always_ff @(posedge mclk) begin
		if (drain) begin
			for (int l = 0; l < SBSP_LANES; l++) begin
				// only enabled lanes change
				if (ent_lanes[l]) begin
					mem_reg[ent_addr][l*SBSP_LANE_W +: SBSP_LANE_W] <=
						ent_data[l*SBSP_LANE_W +: SBSP_LANE_W];
				end
			end
		end
	end

	// flow-through read of the location of this cycle
	assign dq_out = mem_reg[cur_addr];

	// pin direction: async enable masked by held state
	always_comb begin
		dq_oe = 1'h0;
		if (output_enable_n) begin
			// high enable: pins are inputs
			dq_oe = 1'h0;
		end else if (op_reg != SBSP_OP_READ) begin
			// write data phase or deselected
			dq_oe = 1'h0;
		end else if (emerge_reg) begin
			// first cycle out of deselect
			dq_oe = 1'h0;
		end else begin
			// read cycle with enable low
			dq_oe = 1'h1;
		end
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	// a fresh selected load
	sequence sel_load_s;
		load_cmd && selected;
	endsequence

	// a step within an active burst
	sequence burst_step_s;
		step_cmd && op_reg != SBSP_OP_IDLE;
	endsequence

	// leaving the deselected state into a read
	sequence emerge_read_s;
		op_reg == SBSP_OP_IDLE ##1 op_reg == SBSP_OP_READ && emerge_reg;
	endsequence

	// gated edge changes nothing
	chk_gate_holds: assert property (
		clock_gate_n |=> $stable(op_reg) && $stable(cnt_reg) &&
			$stable(addr_hi_reg) && $stable(dq_oe))
	else $error("state moved on a gated edge");

	// load takes the address and clears position
	chk_addr_load: assert property (
		sel_load_s |=> addr_hi_reg == $past(addr_hi) &&
			cnt_reg == SBSP_CNT_ZERO &&
			start_reg == $past({burst_start_bit_one, burst_start_bit_zero}))
	else $error("address not loaded");

	// step advances by one and keeps upper bits
	chk_burst_step: assert property (
		burst_step_s |=> cnt_reg == $past(cnt_reg) + SBSP_CNT_ONE &&
			$stable(addr_hi_reg) && $stable(op_reg))
	else $error("burst step wrong");

	// deselect on any other select combination
	chk_deselect: assert property (
		load_cmd && !selected |=> op_reg == SBSP_OP_IDLE ##0 !dq_oe)
	else $error("not deselected");

	// write starts only from a low strobe
	chk_write_start: assert property (
		sel_load_s ##0 write_n |=> op_reg == SBSP_OP_READ)
	else $error("write without strobe");

	// write data phase never drives
	chk_write_quiet: assert property (
		op_reg == SBSP_OP_WRITE |-> !dq_oe)
	else $error("drive in write phase");

	// first cycle after deselect stays off
	chk_emerge_off: assert property (
		emerge_read_s |-> !dq_oe)
	else $error("drive right after deselect");

	// read with enable low drives after the first cycle
	chk_read_drive: assert property (
		op_reg == SBSP_OP_READ && !emerge_reg && !output_enable_n |-> dq_oe)
	else $error("read not driven");

	// a write data phase with no lanes enabled pushes nothing
	chk_write_push: assert property (
		qual && op_reg == SBSP_OP_WRITE && lane_en_reg == '0 |->
			!wbuf.in_valid)
	else $error("push without lanes");

	// a read returns the array word of this location
	chk_flow_read: assert property (
		dq_oe |-> dq_out == mem_reg[{addr_hi_reg,
			sbsp_burst_off(start_reg, cnt_reg, linear_reg)}])
	else $error("read data mismatch");

	// high enable always releases the pins
	chk_oe_release: assert property (
		output_enable_n |-> !dq_oe)
	else $error("drive with enable high");

	// deselected cycles never drive
	chk_desel_quiet: assert property (
		op_reg == SBSP_OP_IDLE |-> !dq_oe)
	else $error("drive while deselected");

	// byte strobes caught inverted on each qualified edge
	chk_lane_catch: assert property (
		qual |=> lane_en_reg == ~$past(lane_wr_n))
	else $error("byte strobes not caught");

	// last position of a group wraps to the first
	chk_cnt_wrap: assert property (
		burst_step_s ##0 cnt_reg == 2'h3 |=> cnt_reg == SBSP_CNT_ZERO)
	else $error("burst counter did not wrap");

	// a selected load with the strobe low starts a write
	chk_write_load: assert property (
		sel_load_s ##0 !write_n |=> op_reg == SBSP_OP_WRITE)
	else $error("write not started");

endmodule

/* core/sbsp_pkg.sv */
// shared constants for the burst memory pin control
package sbsp_pkg;

	// data path shape: four lanes of eight data bits plus one parity bit
	localparam int SBSP_LANES = 4;
	localparam int SBSP_LANE_W = 9;
	localparam int SBSP_DATA_W = SBSP_LANES * SBSP_LANE_W;

	// burst counter width and address bits above it
	localparam int SBSP_BURST_W = 2;
	localparam int SBSP_ADDR_HI_W = 4;

	// depth of the write data buffer
	localparam int SBSP_FIFO_DEPTH = 4;

	// counter constants
	localparam logic [SBSP_BURST_W-1:0] SBSP_CNT_ZERO = 2'h0;
	localparam logic [SBSP_BURST_W-1:0] SBSP_CNT_ONE = 2'h1;

	// strap level that selects the linear order
	localparam logic SBSP_STRAP_LINEAR = 1'h0;

	// clock period in ns, for reference of cycle counts
	localparam int SBSP_CLK_PERIOD_NS = 100;

	// operation held for the current cycle
	typedef enum logic [1:0] {
		SBSP_OP_IDLE,
		SBSP_OP_READ,
		SBSP_OP_WRITE
	} sbsp_op_e;

	// low address bits for a burst step
	function automatic logic [SBSP_BURST_W-1:0] sbsp_burst_off(
		input logic [SBSP_BURST_W-1:0] start,
		input logic [SBSP_BURST_W-1:0] cnt,
		input logic linear);
		// linear adds, interleaved flips bits
		if (linear) begin
			sbsp_burst_off = start + cnt;
		end else begin
			sbsp_burst_off = start ^ cnt;
		end
	endfunction

endpackage

/* core/sbsp_fifo_if.sv */
`timescale 1ns/1ps
// handshake bundle between the control and its write buffer
interface sbsp_fifo_if #(parameter int WIDTH = 8);
	// filling side
	logic [WIDTH-1:0] in_data;
	logic in_valid;
	logic in_ready;
	// draining side
	logic [WIDTH-1:0] out_data;
	logic out_valid;
	logic out_ready;

	// control view: fills and drains
	modport ctrl (output in_data, output in_valid, input in_ready,
		input out_data, input out_valid, output out_ready);
	// buffer view
	modport store (input in_data, input in_valid, output in_ready,
		output out_data, output out_valid, input out_ready);
endinterface

/* core/sbsp_fifo.sv */
`timescale 1ns/1ps
// small flop buffer, width and depth set by parameters
module sbsp_fifo_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// both handshake sides
	sbsp_fifo_if.store link
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] slot_reg [DEPTH]; // storage words
	logic [PTR_W-1:0] wr_ptr_reg; // next slot to fill
	logic [PTR_W-1:0] rd_ptr_reg; // oldest slot
	logic [CNT_W-1:0] count_reg; // words held
	logic push; // accepted write
	logic pop; // accepted read

	// honest full and empty
	assign link.in_ready = (count_reg != CNT_FULL);
	assign link.out_valid = (count_reg != '0);
	assign link.out_data = slot_reg[rd_ptr_reg];
	assign push = link.in_valid && link.in_ready;
	assign pop = link.out_valid && link.out_ready;

	// storage write
	always_ff @(posedge mclk) begin
		if (push) begin
			slot_reg[wr_ptr_reg] <= link.in_data;
		end
	end

	// pointers wrap at the last slot
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_ONE;
			end
		end
	end

	// occupancy
	always_ff @(posedge mclk) begin
		if (srst) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + CNT_ONE;
		end else if (pop && !push) begin
			count_reg <= count_reg - CNT_ONE;
		end
	end
endmodule

/* tb/sbsp_host.sv */
`timescale 1ns/1ps
// host side of the pin bus: one command per cycle, set at falling edge
module sbsp_host import sbsp_pkg::*; (
	// clock
	input wire logic mclk,
	// command pins
	output logic [SBSP_ADDR_HI_W-1:0] addr_hi,
	output logic burst_start_bit_zero,
	output logic burst_start_bit_one,
	output logic byte_lane_write_n_0,
	output logic byte_lane_write_n_1,
	output logic byte_lane_write_n_2,
	output logic byte_lane_write_n_3,
	output logic write_n,
	output logic burst_step_or_load,
	output logic clock_gate_n,
	output logic chip_select_low_a,
	output logic chip_select_high,
	output logic chip_select_low_b,
	output logic output_enable_n,
	// data toward the device
	output logic [SBSP_DATA_W-1:0] dq_in
);
	logic drv_reg; // host drives a data phase
	logic [SBSP_DATA_W-1:0] wd_reg; // word of that phase
	logic [SBSP_DATA_W-1:0] noise_reg; // released bus pattern

	// released bus never holds the last value
	always @(negedge mclk) noise_reg <= ~noise_reg;
	assign dq_in = drv_reg ? wd_reg : noise_reg;

	// quiet, deselected pins from time zero
	initial begin
		noise_reg = 36'h5A5A5A5A5;
		drv_reg = 1'h0;
		wd_reg = 36'h0;
		clock_gate_n = 1'h0;
		output_enable_n = 1'h0;
		write_n = 1'h1;
		burst_step_or_load = 1'h0;
		addr_hi = 4'h0;
		{burst_start_bit_one, burst_start_bit_zero} = 2'h0;
		{byte_lane_write_n_3, byte_lane_write_n_2} = 2'h3;
		{byte_lane_write_n_1, byte_lane_write_n_0} = 2'h3;
		{chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h7;
	end

	// present one command and the data of the previous one
	task go(input logic [3:0] h, input logic [1:0] s, input logic p, w,
		input logic [3:0] b = 4'h0, input logic [2:0] c = 3'h2,
		input logic d = 1'h0, input logic [35:0] x = 36'h0);
		@(negedge mclk);
		addr_hi = h;
		{burst_start_bit_one, burst_start_bit_zero} = s;
		burst_step_or_load = p;
		write_n = w;
		{byte_lane_write_n_3, byte_lane_write_n_2} = b[3:2];
		{byte_lane_write_n_1, byte_lane_write_n_0} = b[1:0];
		{chip_select_low_a, chip_select_high, chip_select_low_b} = c;
		drv_reg = d;
		wd_reg = x;
	endtask
endmodule

/* tb/sync_burst_sram_pin_control_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the burst memory pin control
module sync_burst_sram_pin_control_tb import sbsp_pkg::*;;
	logic mclk; // 10 MHz clock
	logic srst; // sync reset
	logic burst_order_strap; // burst order strap
	wire logic [SBSP_ADDR_HI_W-1:0] addr_hi;
	wire logic burst_start_bit_zero, burst_start_bit_one;
	wire logic byte_lane_write_n_0, byte_lane_write_n_1;
	wire logic byte_lane_write_n_2, byte_lane_write_n_3, write_n;
	wire logic burst_step_or_load, clock_gate_n, output_enable_n;
	wire logic chip_select_low_a, chip_select_high, chip_select_low_b;
	wire logic [SBSP_DATA_W-1:0] dq_in, dq_out;
	wire logic dq_oe, write_buffer_ready;
	int num_errors; // mismatches
	int compares; // comparisons made
	logic [SBSP_DATA_W-1:0] exp_mem [0:63]; // expected contents

	sbsp_host sbsp_host_inst (.*);
	sbsp_ctrl #(.ADDR_HI_W(4), .FIFO_DEPTH(SBSP_FIFO_DEPTH))
		sbsp_ctrl_inst (.*);

	// free running clock
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	// one bit result
	task cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	// data word result
	task cmp_word(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	// deselected cycles, also lets the buffer drain
	task idle(input int n);
		repeat (n) sbsp_host_inst.go(4'h0, 2'h0, 1'h0, 1'h1, 4'hF, 3'h7);
	endtask

	// location of burst beat k
	function logic [5:0] loc(input logic [3:0] h, input logic [1:0] s,
		input logic [1:0] k, input logic lin);
		loc = {h, lin ? s + k : s ^ k};
	endfunction

	// four beat write burst, last beat deselects
	task wburst(input logic [3:0] h, input logic [1:0] s,
		input logic [35:0] base);
		sbsp_host_inst.go(h, s, 1'h0, 1'h0);
		for (int k = 0; k < 4; k++) begin
			sbsp_host_inst.go(h, s, k < 3, 1'h0, 4'h0,
				k < 3 ? 3'h2 : 3'h7, 1'h1, base + k);
			#1 cmp_bit(dq_oe, 1'h0);
			exp_mem[loc(h, s, k[1:0], 1'h1)] = base + k;
		end
		idle(3);
	endtask

	// four beat read burst; optional gating and enable toggling
	task rburst(input logic [3:0] h, input logic [1:0] s,
		input logic lin, input logic tog);
		sbsp_host_inst.go(h, s, 1'h0, 1'h1);
		for (int k = 0; k < 4; k++) begin
			sbsp_host_inst.go(h, s, k < 3, 1'h1, 4'h0, k < 3 ? 3'h2 : 3'h7);
			#1 cmp_bit(dq_oe, k != 0);
			cmp_word(dq_out, exp_mem[loc(h, s, k[1:0], lin)]);
			if (tog && k == 1) begin
				sbsp_host_inst.clock_gate_n = 1'h1;
				repeat (2) @(negedge mclk);
				cmp_bit(dq_oe, 1'h1);
				cmp_word(dq_out, exp_mem[loc(h, s, 2'h1, lin)]);
				sbsp_host_inst.clock_gate_n = 1'h0;
			end
			if (tog && k == 2) begin
				sbsp_host_inst.output_enable_n = 1'h1;
				#1 cmp_bit(dq_oe, 1'h0);
				sbsp_host_inst.output_enable_n = 1'h0;
				#1 cmp_bit(dq_oe, 1'h1);
			end
		end
		idle(1);
	endtask

	// every chip select combination after an active read
	task cs_test;
		for (int c = 0; c < 8; c++) begin
			sbsp_host_inst.go(4'h3, 2'h2, 1'h0, 1'h1);
			sbsp_host_inst.go(4'h3, 2'h2, 1'h0, 1'h1, 4'h0, c[2:0]);
			idle(1);
			#1 cmp_bit(dq_oe, c == 2);
		end
	endtask

	// lanes 1 and 3 only overwrite one word
	task lane_test;
		wburst(4'h5, 2'h0, 36'h0F0F0F0F0);
		sbsp_host_inst.go(4'h5, 2'h0, 1'h0, 1'h0);
		sbsp_host_inst.go(4'h5, 2'h0, 1'h0, 1'h0, 4'h5, 3'h2, 1'h1,
			36'h123456789);
		sbsp_host_inst.go(4'h0, 2'h0, 1'h0, 1'h1, 4'hF, 3'h7, 1'h1,
			36'hFEDCBA987);
		idle(3);
		// strobes taken at the command edge steer the next data phase:
		// the second word keeps lanes 0 and 2 of the first word
		exp_mem[6'h14] = 36'hFEB47A989;
		rburst(4'h5, 2'h0, 1'h1, 1'h0);
	endtask

	// write and read back to back, then drain the buffer
	task buf_test;
		for (int i = 0; i < 6; i++) begin
			sbsp_host_inst.go(4'h7, i[1:0], 1'h0, 1'h0);
			sbsp_host_inst.go(4'h7, i[1:0], 1'h0, 1'h1, 4'h0, 3'h2, 1'h1,
				36'hC00000000 + i);
			exp_mem[{4'h7, i[1:0]}] = 36'hC00000000 + i;
		end
		idle(6);
		cmp_bit(write_buffer_ready, 1'h1);
		rburst(4'h7, 2'h0, 1'h1, 1'h0);
	endtask

	// strap high at reset gives interleaved order
	task strap_test;
		srst = 1'h1;
		burst_order_strap = 1'h1;
		repeat (4) @(negedge mclk);
		srst = 1'h0;
		rburst(4'h3, 2'h2, 1'h0, 1'h0);
	endtask

	// counts, verdict, end of run
	task final_report;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard, far beyond the run length
	initial begin
		#3000000;
		num_errors++;
		final_report();
	end

	// main sequence
	initial begin
		num_errors = 0;
		compares = 0;
		srst = 1'h1;
		burst_order_strap = 1'h0;
		repeat (4) @(negedge mclk);
		srst = 1'h0;
		cmp_bit(dq_oe, 1'h0);
		cmp_bit(write_buffer_ready, 1'h1);
		wburst(4'h3, 2'h2, 36'h9ABCDEF00);
		rburst(4'h3, 2'h2, 1'h1, 1'h1);
		cs_test();
		lane_test();
		buf_test();
		strap_test();
		final_report();
	end
endmodule
